// [verilog/bxoc_cfg_regs.v]
// APB register bank for bias calibration status, crystal oscillator, divider and driver control
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bxoc_regs.vh"

module bxoc_cfg_regs
(
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Bias calibration engine
   input  wire        cal_done,
   input  wire        cal_fail,
   input  wire [2:0]  cal_sel,
   input  wire [2:0]  cal_eff,
   input  wire        cal_cmp,
   // Crystal oscillator controls
   output wire        crystal_regulator_on,
   output wire [1:0]  xo_gain_boost,
   output wire [5:0]  xo_cap_out,
   output wire [5:0]  xo_cap_in,
   // Output divider controls
   output wire        divider_regulator_on,
   output wire [13:0] divide_ratio,
   // Output driver
   input  wire        ext_out_disable,
   input  wire        clk_div_in,
   output wire [1:0]  driver_type,
   output wire        driver_power_down,
   output reg         clock_pos_pin,
   output reg         clock_pos_pin_oe,
   output reg         clock_neg_pin,
   output reg         clock_neg_pin_oe,
   // Interrupt
   output wire        irq
);

   //--------------------------------------------------------------------------------
   // Registers and decode
   //--------------------------------------------------------------------------------
   reg  [31:0]                 xo_cfg_q;
   reg  [31:0]                 od_cfg_q;
   reg  [31:0]                 drv_cfg_q;
   reg  [1:0]                  drv_type_q;
   reg  [`BXOC_IRQ_WIDTH-1:0]  irq_sts_q;
   reg  [`BXOC_IRQ_WIDTH-1:0]  irq_mask_q;
   reg                         done_q;
   reg  [`BXOC_IRQ_WIDTH-1:0]  irq_sts_d;
   reg                         addr_ok;
   wire                        wr_en;
   wire                        rd_en;
   wire [15:0]                 bias_sts;
   wire                        drv_enabled;
   wire [`BXOC_IRQ_WIDTH-1:0]  irq_evt;

   // Merge write data under a mask so read-only bits never change
   function [31:0] bxoc_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] wmask;
      begin
         bxoc_merge = (old_val & ~wmask) | (new_val & wmask);
      end
   endfunction

   // Clamp reserved capacitance codes to the top step so the array never sees them
   function [5:0] bxoc_cap;
      input [5:0] code;
      begin
         bxoc_cap = (code > `BXOC_CAP_MAX) ? `BXOC_CAP_MAX : code;
      end
   endfunction

   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;

   // Bias status word is a live view of the calibration engine
   assign bias_sts = {7'h00,
                      cal_cmp,
                      cal_eff,
                      cal_sel,
                      cal_fail,
                      cal_done};

   //--------------------------------------------------------------------------------
   // Read mux
   //--------------------------------------------------------------------------------
   // Unmapped offsets read zero; writes there are dropped
   always @*
   begin
      addr_ok = 1'b1;
      case (paddr)
         `BXOC_OFF_BIAS_STS:   prdata = {16'h0000, bias_sts};
         `BXOC_OFF_XO_CFG:     prdata = xo_cfg_q;
         `BXOC_OFF_ODIV_CFG:   prdata = od_cfg_q;
         `BXOC_OFF_DRV_EN_CFG: prdata = drv_cfg_q;
         `BXOC_OFF_DRV_TYPE:   prdata = {30'h0000_0000, drv_type_q};
         `BXOC_OFF_IRQ_STS:    prdata = {30'h0000_0000, irq_sts_q};
         `BXOC_OFF_IRQ_MASK:   prdata = {30'h0000_0000, irq_mask_q};
         default:
         begin
            prdata  = 32'h0000_0000;
            addr_ok = 1'b0;
         end
      endcase
   end

   //--------------------------------------------------------------------------------
   // Configuration registers
   //--------------------------------------------------------------------------------
   // Write masks keep read-only reserved bits at zero, read-write reserved bits stored
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xo_cfg_q   <= `BXOC_XO_RESET;
         od_cfg_q   <= `BXOC_OD_RESET;
         drv_cfg_q  <= `BXOC_DRV_RESET;
         drv_type_q <= `BXOC_TYPE_HCSL;
         irq_mask_q <= {`BXOC_IRQ_WIDTH{1'b0}};
      end
      else if (wr_en && addr_ok)
      begin
         case (paddr)
            `BXOC_OFF_XO_CFG:
               xo_cfg_q <= bxoc_merge(xo_cfg_q, pwdata, `BXOC_XO_WMASK);
            `BXOC_OFF_ODIV_CFG:
               od_cfg_q <= bxoc_merge(od_cfg_q, pwdata, `BXOC_OD_WMASK);
            `BXOC_OFF_DRV_EN_CFG:
               drv_cfg_q <= bxoc_merge(drv_cfg_q, pwdata, `BXOC_DRV_WMASK);
            `BXOC_OFF_DRV_TYPE:
               drv_type_q <= pwdata[1:0];
            `BXOC_OFF_IRQ_MASK:
               irq_mask_q <= pwdata[`BXOC_IRQ_WIDTH-1:0];
            default:
               drv_type_q <= drv_type_q;
         endcase
      end
   end

   //--------------------------------------------------------------------------------
   // Interrupts
   //--------------------------------------------------------------------------------
   // Events: calibration completes, and it completes with a failure
   assign irq_evt[`BXOC_IRQ_DONE] = cal_done & ~done_q;
   assign irq_evt[`BXOC_IRQ_FAIL] = cal_done & ~done_q & cal_fail;

   // Read clears status, but an event in the same cycle survives the clear
   always @*
   begin
      irq_sts_d = irq_sts_q;
      if (rd_en && paddr == `BXOC_OFF_IRQ_STS)
         irq_sts_d = {`BXOC_IRQ_WIDTH{1'b0}};
      irq_sts_d = irq_sts_d | irq_evt;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_q    <= 1'b0;
         irq_sts_q <= {`BXOC_IRQ_WIDTH{1'b0}};
      end
      else
      begin
         done_q    <= cal_done;
         irq_sts_q <= irq_sts_d;
      end
   end

   assign irq = |(irq_sts_q & irq_mask_q);

   //--------------------------------------------------------------------------------
   // Analog control outputs
   //--------------------------------------------------------------------------------
   assign crystal_regulator_on = xo_cfg_q[`BXOC_XO_LDO];
   assign xo_gain_boost        = xo_cfg_q[15:14];
   assign xo_cap_out           = bxoc_cap(xo_cfg_q[13:8]);
   assign xo_cap_in            = bxoc_cap(xo_cfg_q[5:0]);
   assign divider_regulator_on = od_cfg_q[`BXOC_OD_LDO];
   assign divide_ratio         = od_cfg_q[13:0];
   assign driver_type          = drv_type_q;
   assign driver_power_down    = drv_cfg_q[`BXOC_DRV_PD];

   // Register bit or external enable pin can disable the driver
   assign drv_enabled = ~drv_cfg_q[`BXOC_DRV_DIS] & ~ext_out_disable;

   //--------------------------------------------------------------------------------
   // Output pin state
   //--------------------------------------------------------------------------------
   // Registered so the pins never glitch while the mux inputs settle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_pos_pin    <= 1'b0;
         clock_neg_pin    <= 1'b0;
         clock_pos_pin_oe <= 1'b0;
         clock_neg_pin_oe <= 1'b0;
      end
      else if (drv_cfg_q[`BXOC_DRV_PD])
      begin
         // Powered down: tri-state, enable sources ignored
         clock_pos_pin    <= 1'b0;
         clock_neg_pin    <= 1'b0;
         clock_pos_pin_oe <= 1'b0;
         clock_neg_pin_oe <= 1'b0;
      end
      else if (drv_enabled || drv_cfg_q[3:2] == `BXOC_DIS_RUN)
      begin
         // Running, or disabled with debug toggling kept on
         clock_pos_pin    <= clk_div_in;
         clock_neg_pin    <= ~clk_div_in;
         clock_pos_pin_oe <= 1'b1;
         clock_neg_pin_oe <= 1'b1;
      end
      else
      begin
         case (drv_cfg_q[3:2])
            `BXOC_DIS_LOLO:
            begin
               clock_pos_pin    <= 1'b0;
               clock_neg_pin    <= (drv_type_q == `BXOC_TYPE_LVDS);
               clock_pos_pin_oe <= 1'b1;
               clock_neg_pin_oe <= 1'b1;
            end
            `BXOC_DIS_LOHI:
            begin
               clock_pos_pin    <= 1'b0;
               clock_neg_pin    <= 1'b1;
               clock_pos_pin_oe <= 1'b1;
               clock_neg_pin_oe <= 1'b1;
            end
            default:
            begin
               clock_pos_pin    <= 1'b0;
               clock_neg_pin    <= 1'b0;
               clock_pos_pin_oe <= 1'b0;
               clock_neg_pin_oe <= 1'b0;
            end
         endcase
      end
   end

endmodule

// [verilog/bxoc_regs.vh]
// Register offsets, field positions, reset values and codes of the bias/XO/output config bank
`ifndef BXOC_REGS_VH
`define BXOC_REGS_VH

// Byte offsets on APB
`define BXOC_OFF_BIAS_STS     12'h000
`define BXOC_OFF_XO_CFG       12'h004
`define BXOC_OFF_ODIV_CFG     12'h008
`define BXOC_OFF_DRV_EN_CFG   12'h00C
`define BXOC_OFF_DRV_TYPE     12'h010
`define BXOC_OFF_IRQ_STS      12'h014
`define BXOC_OFF_IRQ_MASK     12'h018

// Bias status fields
`define BXOC_BIAS_DONE        0
`define BXOC_BIAS_FAIL        1
`define BXOC_BIAS_SEL_LO      2
`define BXOC_BIAS_EFF_LO      5
`define BXOC_BIAS_CMP         8

// Crystal oscillator config fields and reset
`define BXOC_XO_LDO           16
`define BXOC_XO_WMASK         32'h0007_FFFF
`define BXOC_XO_RESET         32'h0001_5F1F
`define BXOC_CAP_MAX          6'h2F

// Output divider config fields and reset
`define BXOC_OD_LDO           15
`define BXOC_OD_WMASK         32'h0000_BFFF
`define BXOC_OD_RESET         32'h0000_8069

// Output driver enable config fields and reset
`define BXOC_DRV_PD           0
`define BXOC_DRV_DIS          1
`define BXOC_DRV_WMASK        32'h0000_000F
`define BXOC_DRV_RESET        32'h0000_0000

// Driver type and disabled-state codes
`define BXOC_TYPE_HCSL        2'h0
`define BXOC_TYPE_LVDS        2'h2
`define BXOC_TYPE_CMOS        2'h3
`define BXOC_DIS_LOLO         2'h0
`define BXOC_DIS_LOHI         2'h1
`define BXOC_DIS_HIZ          2'h2
`define BXOC_DIS_RUN          2'h3

// Interrupt status bits
`define BXOC_IRQ_DONE         0
`define BXOC_IRQ_FAIL         1
`define BXOC_IRQ_WIDTH        2

`endif

// [testbench/bxoc_cfg_regs_properties.sv]
// Concurrent checks on the bias, crystal and output configuration bank
`timescale 1ns/1ps
`include "bxoc_regs.vh"
module bxoc_cfg_chk
(
   // Clock, reset and APB
   input        pclk,
   input        presetn,
   input        psel,
   input        penable,
   input        pwrite,
   input [11:0] paddr,
   input [31:0] pwdata,
   input [31:0] prdata,
   // Calibration engine
   input        cal_done,
   input        cal_fail,
   input [2:0]  cal_sel,
   input [2:0]  cal_eff,
   input        cal_cmp,
   // Controls and pins
   input        crystal_regulator_on,
   input [5:0]  xo_cap_out,
   input        divider_regulator_on,
   input        ext_out_disable,
   input        clk_div_in,
   input [1:0]  driver_type,
   input        driver_power_down,
   input        clock_pos_pin,
   input        clock_pos_pin_oe,
   input        clock_neg_pin,
   input        clock_neg_pin_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       wr_stb;
   logic       held_off;
   logic [3:0] drv_q;
   logic [5:0] cap_w;
   // Write strobe, powered-but-disabled driver, clamped capacitance code
   assign wr_stb   = psel & penable & pwrite;
   assign held_off = !driver_power_down & (drv_q[1] | ext_out_disable);
   assign cap_w    = (pwdata[13:8] > 6'h2F) ? 6'h2F : pwdata[13:8];
   // Shadow of the driver word; the state field is not visible at the ports
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         drv_q <= 4'h0;
      else if (wr_stb && paddr == `BXOC_OFF_DRV_EN_CFG)
         drv_q <= pwdata[3:0];
   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   bias_readback_a: assert property (psel && penable && !pwrite
      && paddr == 12'h000 |-> prdata == {23'h0, cal_cmp, cal_eff, cal_sel, cal_fail, cal_done})
      else $error("bias status readback wrong");
   xo_ldo_a: assert property (wr_stb && paddr == `BXOC_OFF_XO_CFG
      |=> crystal_regulator_on == $past(pwdata[16])) else $error("xo regulator wrong");
   cap_clamp_a: assert property (wr_stb && paddr == `BXOC_OFF_XO_CFG
      |=> xo_cap_out == $past(cap_w)) else $error("xo output cap wrong");
   od_ldo_a: assert property (wr_stb && paddr == `BXOC_OFF_ODIV_CFG
      |=> divider_regulator_on == $past(pwdata[15])) else $error("divider regulator wrong");
   pd_tristate_a: assert property (driver_power_down
      |=> !clock_pos_pin_oe && !clock_neg_pin_oe) else $error("powered-down pins driven");
   drv_running_a: assert property (!driver_power_down && !drv_q[1] && !ext_out_disable
      |=> clock_pos_pin_oe && clock_neg_pin_oe && clock_pos_pin == $past(clk_div_in)
      && clock_neg_pin != $past(clk_div_in)) else $error("enabled driver not toggling");
   dis_hiz_a: assert property (held_off && drv_q[3:2] == `BXOC_DIS_HIZ
      |=> !clock_pos_pin_oe && !clock_neg_pin_oe) else $error("hi-z state driven");
   lvds_hold_a: assert property (held_off && drv_q[3:2] == `BXOC_DIS_LOLO
      && driver_type == `BXOC_TYPE_LVDS |=> clock_pos_pin_oe && clock_neg_pin_oe
      && !clock_pos_pin && clock_neg_pin) else $error("lvds low state wrong");
   // Main scenarios reached
   cover property (held_off && drv_q[3:2] == `BXOC_DIS_RUN);
   cover property (held_off && driver_type == `BXOC_TYPE_CMOS);
   cover property (wr_stb && paddr == `BXOC_OFF_XO_CFG && pwdata[13:8] > 6'h2F);
endmodule
bind bxoc_cfg_regs bxoc_cfg_chk i_chk (.*);

// [testbench/test_bxoc_cfg_regs.sv]
// Self-checking bench for the bias, crystal and output configuration bank
`timescale 1ns/1ps
`include "bxoc_regs.vh"
module test_bxoc_cfg_regs;
   reg         pclk, presetn, psel, penable, pwrite, cal_done, cal_fail, cal_cmp;
   reg         ext_out_disable, clk_div_in;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, q;
   reg  [2:0]  cal_sel, cal_eff;
   wire        pready, pslverr, crystal_regulator_on, divider_regulator_on, irq;
   wire        driver_power_down, clock_pos_pin, clock_pos_pin_oe, clock_neg_pin, clock_neg_pin_oe;
   wire [31:0] prdata;
   wire [1:0]  xo_gain_boost, driver_type;
   wire [5:0]  xo_cap_out, xo_cap_in;
   wire [13:0] divide_ratio;
   integer     miscompares, checked, i;
   bxoc_cfg_regs i_dut (.*);
   // Bus clock and a divided clock that flips on every rising edge
   always #20 pclk = ~pclk;
   always @(posedge pclk) clk_div_in <= ~clk_div_in;
   // One APB transfer; an idle edge first keeps back-to-back calls clean
   task io(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      {psel, penable} <= 2'b00;
   end
   endtask
   task chk(input [31:0] s, input [31:0] e);
   begin
      checked = checked + 1;
      if (s !== e)
      begin
         miscompares = miscompares + 1;
         $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
      end
   end
   endtask
   task give_verdict;
   begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #200000;
      miscompares = miscompares + 1;
      give_verdict;
   end
   //------------------------------------------------------------
   // Tests
   //------------------------------------------------------------
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, cal_done, cal_fail, cal_cmp} = 8'h00;
      {ext_out_disable, clk_div_in, paddr, pwdata} = 46'h0;
      {cal_sel, cal_eff, miscompares, checked} = {3'h5, 3'h6, 64'h0};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      io(0, `BXOC_OFF_XO_CFG, 0);
      chk(q, 32'h0001_5F1F);
      io(0, `BXOC_OFF_ODIV_CFG, 0);
      chk(q, 32'h0000_8069);
      io(0, `BXOC_OFF_BIAS_STS, 0);
      chk(q, 32'h0000_00D4);
      $display("reset values done");
      io(1, `BXOC_OFF_IRQ_MASK, 32'h0000_0003);
      {cal_done, cal_fail, cal_cmp} <= 3'h7;
      io(1, `BXOC_OFF_BIAS_STS, 32'hFFFF_FFFF);
      io(0, `BXOC_OFF_BIAS_STS, 0);
      chk(q, 32'h0000_01D7);
      chk(irq, 1'b1);
      io(0, `BXOC_OFF_IRQ_STS, 0);
      chk(q, 32'h0000_0003);
      {cal_done, cal_fail} <= 2'b00;
      io(1, `BXOC_OFF_IRQ_MASK, 0);
      cal_done <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      io(0, `BXOC_OFF_IRQ_STS, 0);
      chk(q, 32'h0000_0001);
      $display("bias status and interrupt done");
      io(1, `BXOC_OFF_XO_CFG, 32'hFFFF_FFFF);
      io(0, `BXOC_OFF_XO_CFG, 0);
      chk(q, 32'h0007_FFFF);
      chk({xo_cap_out, xo_cap_in}, 12'hBEF);
      io(1, `BXOC_OFF_XO_CFG, 32'h0000_2E05);
      // The write lands on the access edge; look once the register has settled
      #1;
      chk({crystal_regulator_on, xo_gain_boost, xo_cap_out, xo_cap_in}, 15'h0B85);
      io(1, `BXOC_OFF_ODIV_CFG, 32'hFFFF_FFFF);
      io(0, `BXOC_OFF_ODIV_CFG, 0);
      chk(q, 32'h0000_BFFF);
      io(1, `BXOC_OFF_ODIV_CFG, 32'h0000_000A);
      #1;
      chk({divider_regulator_on, divide_ratio}, 15'h000A);
      chk({pready, pslverr}, 2'b10);
      io(1, 12'h100, 32'hFFFF_FFFF);
      io(0, 12'h100, 0);
      chk(q, 0);
      $display("configuration registers done");
      for (i = 0; i < 4; i = i + 1)
      begin
         io(1, `BXOC_OFF_DRV_TYPE, i);
         io(1, `BXOC_OFF_DRV_EN_CFG, 32'h0000_0002);
         repeat (2) @(posedge pclk);
         chk({driver_type, clock_pos_pin_oe, clock_neg_pin_oe, clock_pos_pin, clock_neg_pin},
             {i[1:0], 3'b110, i == 2});
      end
      for (i = 1; i < 4; i = i + 1)
      begin
         io(1, `BXOC_OFF_DRV_EN_CFG, {i[1:0], 2'b10});
         repeat (2) @(posedge pclk);
         chk({clock_pos_pin_oe, clock_neg_pin_oe}, (i == 2) ? 2'b00 : 2'b11);
         if (i != 2)
            chk({clock_pos_pin, clock_neg_pin}, (i == 1) ? 2'b01 : {~clk_div_in, clk_div_in});
      end
      io(1, `BXOC_OFF_DRV_EN_CFG, 32'h0000_0008);
      repeat (2) @(posedge pclk);
      chk({clock_pos_pin_oe, clock_neg_pin_oe}, 2'b11);
      ext_out_disable <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({clock_pos_pin_oe, clock_neg_pin_oe}, 2'b00);
      io(1, `BXOC_OFF_DRV_EN_CFG, 32'h0000_000D);
      ext_out_disable <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({clock_pos_pin_oe, clock_neg_pin_oe, driver_power_down}, 3'b001);
      $display("driver states done");
      give_verdict;
   end
endmodule
